/* File: rtl/gpm_power_mode_control.sv */
/*
 gpm_power_mode_control: charge termination, inhibit/suspend flags, power
 mode machine, wake comparator, flash voltage gate and offset calibration.
 assumes: measurements arrive from logic on the same clock; updateTick marks
 the end of each measurement period; secTick pulses once a second.
*/
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
// Contract
// - termination needs two taper periods of low current, capacity gain, high voltage
// - on termination clear charging; optionally load remaining with full capacity
// - temperature outside inhibit limits sets inhibit and drops battery good
// - inhibit clears, battery good returns, inside hysteresis-narrowed inhibit window
// - with suspend enabled, outside suspend limits sets the suspend flag
// - suspend clears inside inhibit window narrowed by hysteresis
// - doze keeps both oscillators; sleep stops fast oscillator, still measures
// - battery wait halts cpu, serves commands; insertion runs ocv, battery good
// - sleep entered when enabled and average current below sleep level
// - sleep left on current above sleep level or wake comparator
// - battery removed under external power: stop gauging, go to battery wait
// - doze entered when doze enabled and current below sleep level
// - doze left on host activity, current above level, or wake comparator
// - hibernate on host request after valid ocv and small current
// - hibernate also on low voltage after valid ocv
// - hibernate wakes only on reset or addressed bus transaction
// - wake threshold chosen by sense bits and range bit; zero sense disables
// - wake comparator fires on crossing in either direction
// - flash write refused when voltage below flash permitted level
// - calibrate on sleep entry unless temperature outside five to forty-five
// - single calibration at low current after voltage or sustained temperature move
// - calibration holds rates, aborts if voltage falls more than 32 mV
`timescale 1ns/1ps
module gpm_power_mode_control
  import gpm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic haddrSel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire gpm_pkg::gpm_meas_t meas,
  input wire logic updateTick,
  input wire logic secTick,
  input wire logic hostActivity,
  input wire logic addrMatch,
  output logic battery_good_out,
  output gpm_pkg::gpm_mode_t modeOut,
  output gpm_pkg::gpm_pwr_t pwrOut,
  output logic wakeIrq,
  output logic flashGrant
);
  import gpm_pkg::*;

  function automatic logic [7:0] wakeThresh(input logic hi, input logic lo, input logic rng);
    case ({hi, lo, rng})
      3'b010: wakeThresh = WAKE_1P0;
      3'b011, 3'b100: wakeThresh = WAKE_2P2;
      3'b101, 3'b110: wakeThresh = WAKE_4P6;
      3'b111: wakeThresh = WAKE_9P8;
      default: wakeThresh = 8'h00;
    endcase
  endfunction : wakeThresh

  function automatic logic [15:0] absv(input logic signed [15:0] v);
    absv = v[15] ? 16'(-v) : 16'(v);
  endfunction : absv

  ////////////////////////////////////////////////////////////////////////
  // register bus
  logic [31:0] cfg_q, tempLim_q, suspLim_q, curLim_q, voltLim_q, taper_q, capFull_q;
  logic [31:0] remCap_q;
  logic [7:0] wAddr_q;
  logic wPend_q;
  logic [2:0] ctrlPulse;
  logic chgFlag_q, inhibit_q, suspend_q, termDone_q, calBusy_q, flashRefused_q, sleepCalDone_q;
  gpm_mode_t mode_q;
  logic termEvent;
  logic [31:0] statusWord;

  wire addrPhase = haddrSel && hready && htrans[1];
  wire [7:0] aOff = haddr[7:0];

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wPend_q <= 1'b0;
      wAddr_q <= 8'h00;
    end
    else
    begin
      wPend_q <= addrPhase && hwrite;
      wAddr_q <= aOff;
    end
  end

  assign ctrlPulse = (wPend_q && wAddr_q == REG_CTRL) ? hwdata[2:0] : 3'b000;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cfg_q <= CFG_RST;
      tempLim_q <= ZERO_RST;
      suspLim_q <= ZERO_RST;
      curLim_q <= ZERO_RST;
      voltLim_q <= ZERO_RST;
      taper_q <= ZERO_RST;
      capFull_q <= ZERO_RST;
    end
    else if (wPend_q)
    begin
      case (wAddr_q)
        REG_CFG: cfg_q <= hwdata;
        REG_TEMPLIM: tempLim_q <= hwdata;
        REG_SUSPLIM: suspLim_q <= hwdata;
        REG_CURLIM: curLim_q <= hwdata;
        REG_VOLTLIM: voltLim_q <= hwdata;
        REG_TAPER: taper_q <= hwdata;
        REG_CAPFULL: capFull_q <= hwdata;
        default: ;
      endcase
    end
  end

  assign statusWord = {21'h0, flashRefused_q, calBusy_q, termDone_q, suspend_q, inhibit_q,
                       chgFlag_q, 2'b00, mode_q};

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrPhase && !hwrite)
      begin
        case (aOff)
          REG_CFG: hrdata <= cfg_q;
          REG_TEMPLIM: hrdata <= tempLim_q;
          REG_SUSPLIM: hrdata <= suspLim_q;
          REG_CURLIM: hrdata <= curLim_q;
          REG_VOLTLIM: hrdata <= voltLim_q;
          REG_TAPER: hrdata <= taper_q;
          REG_CAPFULL: hrdata <= capFull_q;
          REG_STATUS: hrdata <= statusWord;
          REG_REMCAP: hrdata <= remCap_q;
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field views of the limit words
  wire signed [15:0] inhLow = tempLim_q[15:0];
  wire signed [15:0] inhHigh = tempLim_q[31:16];
  wire signed [15:0] susLow = suspLim_q[15:0];
  wire signed [15:0] susHigh = suspLim_q[31:16];
  wire signed [15:0] tempHys = 16'(signed'({8'h00, taper_q[31:24]}));
  wire signed [15:0] sleepCur = curLim_q[15:0];
  wire [15:0] hibCur = curLim_q[31:16];
  wire [15:0] hibVolt = voltLim_q[15:0];
  wire [15:0] flashVolt = voltLim_q[31:16];
  wire signed [15:0] taperCur = 16'(signed'({8'h00, taper_q[7:0]}));
  wire [15:0] minTaperChg = {8'h00, taper_q[15:8]};
  wire [15:0] chgVoltTaper = {8'h00, taper_q[23:16]};
  wire [15:0] chgVolt = capFull_q[31:16];
  wire signed [15:0] t = meas.temp;
  wire inHysWin = (t >= 16'(inhLow + tempHys)) && (t <= 16'(inhHigh - tempHys));

  ////////////////////////////////////////////////////////////////////////
  // charge termination and temperature flags
  logic [1:0] taperCnt_q;
  wire taperOk = (meas.avgCur < taperCur) && (meas.capDelta > minTaperChg);
  assign termEvent = updateTick && taperOk && (taperCnt_q == 2'(TAPER_PERIODS - 1))
                     && (meas.volt > 16'(chgVolt - chgVoltTaper));

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      taperCnt_q <= 2'b00;
      termDone_q <= 1'b0;
    end
    else if (updateTick)
    begin
      taperCnt_q <= taperOk ? ((taperCnt_q == 2'(TAPER_PERIODS - 1)) ? taperCnt_q
                                : 2'(taperCnt_q + 2'b01)) : 2'b00;
      termDone_q <= termEvent || (termDone_q && meas.avgCur < taperCur);
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      chgFlag_q <= 1'b0;
      remCap_q <= ZERO_RST;
    end
    else if (termEvent)
    begin
      chgFlag_q <= 1'b0;
      if (cfg_q[CFG_REM_FULL])
        remCap_q <= {16'h0000, capFull_q[15:0]};
    end
    else if (updateTick && !calBusy_q)
    begin
      chgFlag_q <= (meas.avgCur > taperCur) && !inhibit_q && !suspend_q;
      remCap_q <= {16'h0000, 16'(remCap_q[15:0] + meas.capDelta)};
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      inhibit_q <= 1'b0;
      suspend_q <= 1'b0;
    end
    else if (updateTick)
    begin
      if (t < inhLow || t > inhHigh)
        inhibit_q <= 1'b1;
      else if (inHysWin)
        inhibit_q <= 1'b0;
      if (cfg_q[CFG_SUSP_EN] && (t < susLow || t > susHigh))
        suspend_q <= 1'b1;
      else if (inHysWin)
        suspend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake comparator and flash gate
  logic wakeHit;
  wire [7:0] wth = wakeThresh(cfg_q[CFG_SENSE_HI], cfg_q[CFG_SENSE_LO],
                              cfg_q[CFG_WAKE_RNG]);
  assign wakeHit = (wth != 8'h00) && (absv(meas.senseUv) > {8'h00, wth});

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wakeIrq <= 1'b0;
      flashGrant <= 1'b0;
      flashRefused_q <= 1'b0;
    end
    else
    begin
      wakeIrq <= wakeHit;
      flashGrant <= ctrlPulse[CTRL_FLASH_REQ] && (meas.volt >= flashVolt);
      if (ctrlPulse[CTRL_FLASH_REQ])
        flashRefused_q <= meas.volt < flashVolt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // offset calibration
  logic [15:0] calVolt_q;
  logic signed [15:0] calTemp_q;
  logic [5:0] tempSec_q;
  wire calTempOk = (t > CAL_TEMP_LO) && (t < CAL_TEMP_HI);
  wire lowCur = meas.avgCur <= CAL_CUR_MAX;
  wire vMoved = absv(16'(meas.volt - calVolt_q)) >= CAL_VSTEP;
  wire tMoved = absv(16'(t - calTemp_q)) > 16'(CAL_TSTEP);
  wire singleCal = lowCur && (vMoved || tempSec_q == 6'(TEMP_HOLD_S));
  wire sleepQual = cfg_q[CFG_SLEEP_EN] && (meas.avgCur < sleepCur);
  wire sleepCal = (mode_q == MODE_NORMAL) && sleepQual && calTempOk && !sleepCalDone_q;
  wire calAbort = calBusy_q && (meas.volt < calVolt_q)
                  && (16'(calVolt_q - meas.volt) > CAL_ABORT_DROP);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      tempSec_q <= 6'h00;
    else if (!tMoved)
      tempSec_q <= 6'h00;
    else if (secTick && tempSec_q != 6'(TEMP_HOLD_S))
      tempSec_q <= 6'(tempSec_q + 6'h01);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      calBusy_q <= 1'b0;
      calVolt_q <= 16'h0000;
      calTemp_q <= 16'sh0000;
    end
    else if (calBusy_q)
    begin
      if (calAbort || ctrlPulse[CTRL_OFFCAL_DONE])
        calBusy_q <= 1'b0;
    end
    else if (updateTick && meas.batPresent && (sleepCal || singleCal))
    begin
      calBusy_q <= 1'b1;
      calVolt_q <= meas.volt;
      calTemp_q <= t;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power mode machine
  logic initDone_q;
  wire curAbove = meas.avgCur >= sleepCur;
  wire hibOk = meas.ocvValid && ((cfg_q[CFG_HIB_REQ] && absv(meas.avgCur) < hibCur)
               || meas.volt < hibVolt);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      mode_q <= MODE_BATWAIT;
      initDone_q <= 1'b0;
      sleepCalDone_q <= 1'b0;
    end
    else
    begin
      if (ctrlPulse[CTRL_INIT_DONE])
        initDone_q <= 1'b1;
      if (mode_q != MODE_NORMAL || !sleepQual)
        sleepCalDone_q <= 1'b0;
      else if (updateTick && sleepCal && meas.batPresent)
        sleepCalDone_q <= 1'b1;
      case (mode_q)
        MODE_BATWAIT:
        begin
          if (initDone_q && meas.batPresent)
            mode_q <= MODE_NORMAL;
        end
        MODE_NORMAL:
        begin
          if (!meas.batPresent)
          begin
            mode_q <= MODE_BATWAIT;
            initDone_q <= 1'b0;
          end
          else if (updateTick && hibOk)
            mode_q <= MODE_HIBERNATE;
          else if (updateTick && sleepQual && !calBusy_q && !sleepCal)
            mode_q <= MODE_SLEEP;
          else if (updateTick && cfg_q[CFG_DOZE_EN] && !curAbove && !hostActivity)
            mode_q <= MODE_DOZE;
        end
        MODE_SLEEP:
        begin
          if (!meas.batPresent)
            mode_q <= MODE_BATWAIT;
          else if (wakeHit || (updateTick && curAbove))
            mode_q <= MODE_NORMAL;
        end
        MODE_DOZE:
        begin
          if (!meas.batPresent)
            mode_q <= MODE_BATWAIT;
          else if (hostActivity || wakeHit || (updateTick && curAbove))
            mode_q <= MODE_NORMAL;
        end
        MODE_HIBERNATE:
        begin
          if (addrMatch)
          begin
            mode_q <= MODE_BATWAIT;
            initDone_q <= 1'b0;
          end
        end
        default: mode_q <= MODE_BATWAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  logic ocvIssued_q;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      modeOut <= MODE_BATWAIT;
      pwrOut <= '0;
      battery_good_out <= 1'b0;
      ocvIssued_q <= 1'b0;
    end
    else
    begin
      modeOut <= mode_q;
      ocvIssued_q <= (mode_q == MODE_BATWAIT) && meas.batPresent;
      pwrOut.haltCpu <= (mode_q == MODE_BATWAIT && !hostActivity)
                        || mode_q == MODE_HIBERNATE;
      pwrOut.hfOscOn <= (mode_q != MODE_SLEEP) && (mode_q != MODE_HIBERNATE);
      pwrOut.lfOscOn <= mode_q != MODE_HIBERNATE;
      pwrOut.gaugeRun <= (mode_q == MODE_NORMAL) || (mode_q == MODE_SLEEP)
                         || (mode_q == MODE_DOZE);
      pwrOut.ocvStart <= (mode_q == MODE_BATWAIT) && meas.batPresent && !ocvIssued_q;
      pwrOut.calRun <= calBusy_q;
      battery_good_out <= (mode_q != MODE_BATWAIT) && (mode_q != MODE_HIBERNATE)
                          && !inhibit_q && meas.ocvValid;
    end
  end

endmodule : gpm_power_mode_control

/* File: rtl/gpm_pkg.sv */
/*
 gpm_pkg: register map, field positions, reset values and mode enumeration
 for the gauge power-mode controller.
 assumes: one 250 MHz clock domain, 32-bit AHB-Lite register access.
*/
package gpm_pkg;

  // register byte addresses
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_TEMPLIM = 8'h04;
  localparam logic [7:0] REG_SUSPLIM = 8'h08;
  localparam logic [7:0] REG_CURLIM = 8'h0c;
  localparam logic [7:0] REG_VOLTLIM = 8'h10;
  localparam logic [7:0] REG_TAPER = 8'h14;
  localparam logic [7:0] REG_CAPFULL = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_REMCAP = 8'h20;
  localparam logic [7:0] REG_CTRL = 8'h24;

  // configuration word fields
  localparam int CFG_SLEEP_EN = 0;
  localparam int CFG_DOZE_EN = 1;
  localparam int CFG_SUSP_EN = 2;
  localparam int CFG_REM_FULL = 3;
  localparam int CFG_SENSE_LO = 4;
  localparam int CFG_SENSE_HI = 5;
  localparam int CFG_WAKE_RNG = 6;
  localparam int CFG_HIB_REQ = 7;

  // control word (write one to pulse)
  localparam int CTRL_FLASH_REQ = 0;
  localparam int CTRL_OFFCAL_DONE = 1;
  localparam int CTRL_INIT_DONE = 2;

  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;

  // calibration limits, in measurement units (mA, mV, 0.1 degC)
  localparam logic signed [15:0] CAL_TEMP_LO = 16'sh0032;
  localparam logic signed [15:0] CAL_TEMP_HI = 16'sh01c2;
  localparam logic signed [15:0] CAL_CUR_MAX = 16'sh0064;
  localparam logic [15:0] CAL_VSTEP = 16'h0100;
  localparam logic signed [15:0] CAL_TSTEP = 16'sh0320;
  localparam logic [15:0] CAL_ABORT_DROP = 16'h0020;
  localparam int TEMP_HOLD_S = 60;
  localparam int TAPER_PERIODS = 2;

  // wake threshold in 0.1 mV steps
  localparam logic [7:0] WAKE_1P0 = 8'h0a;
  localparam logic [7:0] WAKE_2P2 = 8'h16;
  localparam logic [7:0] WAKE_4P6 = 8'h2e;
  localparam logic [7:0] WAKE_9P8 = 8'h62;

  typedef enum logic [2:0] {
    MODE_BATWAIT,
    MODE_NORMAL,
    MODE_SLEEP,
    MODE_DOZE,
    MODE_HIBERNATE
  } gpm_mode_t;

  typedef struct packed {
    logic signed [15:0] avgCur;
    logic [15:0] volt;
    logic signed [15:0] temp;
    logic signed [15:0] senseUv;
    logic [15:0] capDelta;
    logic batPresent;
    logic ocvValid;
  } gpm_meas_t;

  typedef struct packed {
    logic haltCpu;
    logic hfOscOn;
    logic lfOscOn;
    logic gaugeRun;
    logic ocvStart;
    logic calRun;
  } gpm_pwr_t;

endpackage : gpm_pkg

/* File: sim/gpm_host_model.sv */
/*
 gpm_host_model: host side of the controller, a single-word AHB-Lite master
 plus the host activity and addressed-transaction lines.
 assumes: one slave whose hreadyout is the bus hready.
*/
`timescale 1ns/1ps
module gpm_host_model (
  input wire logic clock,
  input wire logic hreadyout,
  output logic haddrSel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic hostActivity,
  output logic addrMatch
);
  initial
  begin
    haddrSel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    hostActivity = 1'b0;
    addrMatch = 1'b0;
  end

  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock);
    haddrSel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, addr};
    do @(posedge clock); while (hreadyout !== 1'b1);
    haddrSel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? data : ~hwdata;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hwdata <= ~data;
  endtask : xfer

  // addressed transaction or other bus traffic
  task automatic wake(input logic addressed);
    @(posedge clock);
    addrMatch <= addressed;
    hostActivity <= 1'b1;
    @(posedge clock);
    addrMatch <= 1'b0;
    hostActivity <= 1'b0;
  endtask : wake
endmodule : gpm_host_model

/* File: sim/gpm_power_mode_control_properties.sv */
/*
 gpm_power_mode_control_properties: port-level checker for the controller.
 assumes: bound to gpm_power_mode_control, single clock, sync reset.
*/
`timescale 1ns/1ps
module gpm_power_mode_control_properties
  import gpm_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic haddrSel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire gpm_pkg::gpm_meas_t meas,
  input wire logic hostActivity,
  input wire logic addrMatch,
  input wire gpm_pkg::gpm_mode_t modeOut,
  input wire gpm_pkg::gpm_pwr_t pwrOut,
  input wire logic wakeIrq,
  input wire logic flashGrant
);
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] cfg_q;
  logic [31:0] volt_q;

  // shadow of the configuration and voltage limit words
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      cfg_q <= 32'h0;
      volt_q <= 32'h0;
    end
    else if (hready)
    begin
      wrPend_q <= haddrSel && htrans[1] && hwrite;
      wrAddr_q <= haddr[7:0];
      if (wrPend_q && wrAddr_q == REG_CFG)
        cfg_q <= hwdata;
      if (wrPend_q && wrAddr_q == REG_VOLTLIM)
        volt_q <= hwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  wake_off_a: assert property ((cfg_q[5:4] == 2'b00)[*2] |-> !wakeIrq)
    else $error("wake flag raised while comparator disabled");
  wake_pos_a: assert property ((cfg_q[6:4] == 3'b111)[*2] ##0 $past(meas.senseUv) > 16'sd98
    |-> wakeIrq) else $error("wake flag missing on charge crossing");
  wake_neg_a: assert property ((cfg_q[6:4] == 3'b111)[*2] ##0 $past(meas.senseUv) < -16'sd98
    |-> wakeIrq) else $error("wake flag missing on discharge crossing");
  flash_volt_a: assert property (flashGrant |-> $past(meas.volt) >= volt_q[31:16])
    else $error("flash granted below permitted voltage");
  flash_pulse_a: assert property (flashGrant |=> !flashGrant)
    else $error("flash grant longer than one cycle");
  sleep_osc_a: assert property ((modeOut == MODE_SLEEP)[*3] |->
    !pwrOut.hfOscOn && pwrOut.lfOscOn) else $error("fast oscillator running in sleep");
  doze_osc_a: assert property ((modeOut == MODE_DOZE)[*3] |->
    pwrOut.hfOscOn && pwrOut.lfOscOn) else $error("oscillator stopped in doze");
  sleep_wake_a: assert property (modeOut == MODE_SLEEP && wakeIrq |->
    ##[1:4] modeOut == MODE_NORMAL) else $error("sleep not left on wake");
  doze_host_a: assert property (modeOut == MODE_DOZE && hostActivity |->
    ##[1:4] modeOut != MODE_DOZE) else $error("doze not left on host activity");
  bat_gone_a: assert property ($fell(meas.batPresent) |->
    ##[1:3] modeOut == MODE_BATWAIT) else $error("battery removal ignored");
  hib_hold_a: assert property (modeOut == MODE_HIBERNATE && !$past(addrMatch) &&
    $past(meas.batPresent) |=> modeOut == MODE_HIBERNATE) else $error("hibernate left early");
endmodule : gpm_power_mode_control_properties

bind gpm_power_mode_control gpm_power_mode_control_properties u_props (
  .clock(clock), .sys_rst(sys_rst), .haddrSel(haddrSel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .meas(meas),
  .hostActivity(hostActivity), .addrMatch(addrMatch), .modeOut(modeOut), .pwrOut(pwrOut),
  .wakeIrq(wakeIrq), .flashGrant(flashGrant)
);

/* File: sim/gpm_tb.sv */
/*
 tb: self-checking bench for the gauge power-mode controller.
 assumes: zero-wait AHB slave, flags evaluated on updateTick.
*/
`timescale 1ns/1ps
module tb;
  import gpm_pkg::*;
  logic clock, sys_rst, haddrSel, hwrite, hready, updateTick, secTick, hostActivity, addrMatch;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, battery_good_out, wakeIrq, flashGrant;
  gpm_meas_t meas;
  gpm_mode_t modeOut;
  gpm_pwr_t pwrOut;
  int errCount = 0, nChecks = 0, grantCnt = 0, g;
  logic rdPend = 1'b0;
  logic [63:0] expQ[$];
  logic [39:0] lim[6];
  logic [18:0] tt[13];
  logic [7:0] th[8];
  logic [15:0] full;
  logic signed [15:0] rnd;

  assign hready = hreadyout;
  gpm_power_mode_control DUT (.clock(clock), .sys_rst(sys_rst), .haddrSel(haddrSel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas(meas),
    .updateTick(updateTick), .secTick(secTick), .hostActivity(hostActivity),
    .addrMatch(addrMatch), .battery_good_out(battery_good_out), .modeOut(modeOut),
    .pwrOut(pwrOut), .wakeIrq(wakeIrq), .flashGrant(flashGrant));
  gpm_host_model host (.clock(clock), .hreadyout(hreadyout), .haddrSel(haddrSel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hostActivity(hostActivity), .addrMatch(addrMatch));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic cmp_rd(input logic [63:0] e, input logic [31:0] got);
    nChecks++;
    if ((got & e[63:32]) !== (e[31:0] & e[63:32]))
    begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e[31:0]);
    end
  endtask : cmp_rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_rd({32'hffff_ffff, exp}, got);
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back({m, e});
    host.xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clock);
      updateTick <= 1'b1;
      @(posedge clock);
      updateTick <= 1'b0;
    end
    repeat (4) @(posedge clock);
  endtask : tick

  // read data is judged where the data phase ends
  always @(posedge clock)
  begin
    if (rdPend && hreadyout === 1'b1 && expQ.size() > 0)
      cmp_rd(expQ.pop_front(), hrdata);
    if (hreadyout === 1'b1)
      rdPend <= haddrSel && htrans[1] && !hwrite;
    if (flashGrant === 1'b1)
      grantCnt++;
  end

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    errCount++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'b1;
    {updateTick, secTick} = 2'b00;
    meas = '{avgCur: 16'sd200, volt: 16'd3700, temp: 16'sd250, senseUv: 16'sd0,
      capDelta: 16'd0, batPresent: 1'b1, ocvValid: 1'b0};
    th = '{8'h00, 8'h00, WAKE_1P0, WAKE_2P2, WAKE_2P2, WAKE_4P6, WAKE_4P6, WAKE_9P8};
    // suspend enable, inhibit, suspend, temperature
    tt = '{{3'b010, 16'd99}, {3'b010, 16'd119}, {3'b000, 16'd120}, {3'b010, 16'd510},
      {3'b000, 16'd380}, {3'b110, 16'd401}, {3'b110, 16'd381}, {3'b100, 16'd380},
      {3'b111, 16'd501}, {3'b111, 16'd390}, {3'b100, 16'd380}, {3'b111, 16'hffff},
      {3'b100, 16'd250}};
    void'($urandom(32'hc029));
    full = 16'($urandom_range(16'hffff, 1));
    lim = '{{REG_TEMPLIM, 32'h0190_0064}, {REG_SUSPLIM, 32'h01f4_0000},
      {REG_CURLIM, 32'h0014_0032}, {REG_VOLTLIM, 32'h0d48_0bb8},
      {REG_TAPER, 32'h1464_0514}, {REG_CAPFULL, 16'h1068, full}};
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    rd(REG_STATUS, 32'h0, 32'hffff_ffff);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    wr(REG_REMCAP, 32'hffff_ffff);
    rd(REG_REMCAP, 32'h0, 32'hffff_ffff);
    foreach (lim[i]) wr(lim[i][39:32], lim[i][31:0]);
    foreach (lim[i]) rd(lim[i][39:32], lim[i][31:0], 32'hffff_ffff);
    chk(battery_good_out, 32'h0);
    wr(REG_CTRL, 32'h4);
    meas.ocvValid <= 1'b1;
    tick(1);
    rd(REG_STATUS, 32'h1, 32'h7);
    chk(battery_good_out, 32'h1);
    foreach (tt[i])
    begin
      wr(REG_CFG, {29'h0, tt[i][18], 2'b00});
      meas.temp <= tt[i][15:0];
      tick(1);
      rd(REG_STATUS, {24'h0, tt[i][16], tt[i][17], 6'h0}, 32'hc0);
      chk(battery_good_out, !tt[i][17]);
    end
    wr(REG_CFG, 32'h8);
    meas.avgCur <= 16'sd10;
    meas.capDelta <= 16'd6;
    meas.volt <= 16'd4150;
    tick(1);
    rd(REG_STATUS, 32'h0, 32'h100);
    tick(1);
    rd(REG_STATUS, 32'h100, 32'h120);
    rd(REG_REMCAP, {16'h0, full}, 32'hffff);
    meas.avgCur <= 16'sd200;
    meas.capDelta <= 16'd0;
    meas.volt <= 16'd3400;
    g = grantCnt;
    wr(REG_CTRL, 32'h1);
    tick(0);
    chk(grantCnt, g + 1);
    meas.volt <= 16'd3399;
    wr(REG_CTRL, 32'h1);
    tick(0);
    chk(grantCnt, g + 1);
    rd(REG_STATUS, 32'h400, 32'h400);
    meas.volt <= 16'd3700;
    for (int i = 0; i < 8; i++)
    begin
      rnd = 16'($urandom_range(60, 1));
      wr(REG_CFG, {25'h0, i[0], i[2], i[1], 4'h0});
      meas.senseUv <= $signed({8'h0, th[i]});
      tick(0);
      chk(wakeIrq, 32'h0);
      meas.senseUv <= -$signed({8'h0, th[i]}) - rnd;
      tick(0);
      chk(wakeIrq, th[i] != 8'h0);
      meas.senseUv <= $signed({8'h0, th[i]}) + rnd;
      tick(0);
      chk(wakeIrq, th[i] != 8'h0);
    end
    meas.senseUv <= 16'sd0;
    wr(REG_CFG, 32'h71);
    meas.avgCur <= 16'sd30;
    for (int k = 0; k < 3; k++)
    begin
      tick(1);
      rd(REG_STATUS, 32'h201, 32'h207);
      if (k < 2)
      begin
        wr(REG_CTRL, 32'h2);
        tick(1);
        rd(REG_STATUS, 32'h2, 32'h207);
        chk(pwrOut.hfOscOn, 32'h0);
        if (k == 0)
          meas.avgCur <= 16'sd200;
        else
          meas.senseUv <= -16'sd150;
        tick(k == 0);
        rd(REG_STATUS, 32'h1, 32'h7);
        meas.avgCur <= 16'sd30;
        meas.senseUv <= 16'sd0;
      end
    end
    meas.volt <= 16'd3668;
    tick(0);
    rd(REG_STATUS, 32'h200, 32'h200);
    meas.volt <= 16'd3667;
    tick(0);
    rd(REG_STATUS, 32'h0, 32'h200);
    meas.avgCur <= 16'sd200;
    meas.volt <= 16'd3700;
    tick(1);
    meas.temp <= 16'sd50;
    meas.avgCur <= 16'sd30;
    tick(1);
    rd(REG_STATUS, 32'h0, 32'h200);
    meas.temp <= 16'sd250;
    meas.avgCur <= 16'sd200;
    tick(1);
    wr(REG_CFG, 32'h2);
    meas.avgCur <= 16'sd30;
    tick(1);
    rd(REG_STATUS, 32'h3, 32'h7);
    host.wake(1'b0);
    tick(0);
    rd(REG_STATUS, 32'h1, 32'h7);
    wr(REG_CFG, 32'h80);
    meas.avgCur <= -16'sd10;
    tick(1);
    rd(REG_STATUS, 32'h4, 32'h7);
    host.wake(1'b0);
    tick(0);
    rd(REG_STATUS, 32'h4, 32'h7);
    host.wake(1'b1);
    tick(0);
    rd(REG_STATUS, 32'h0, 32'h7);
    wr(REG_CFG, 32'h0);
    meas.avgCur <= 16'sd200;
    wr(REG_CTRL, 32'h4);
    tick(1);
    rd(REG_STATUS, 32'h1, 32'h7);
    meas.volt <= 16'd2999;
    tick(1);
    rd(REG_STATUS, 32'h4, 32'h7);
    meas.volt <= 16'd3700;
    host.wake(1'b1);
    wr(REG_CTRL, 32'h4);
    tick(1);
    meas.batPresent <= 1'b0;
    tick(0);
    rd(REG_STATUS, 32'h0, 32'h7);
    tick(0);
    tally_and_finish();
  end
endmodule : tb
